// >>> rtl/tws_pkg.sv
// Package: register map, field positions, timing and pin types
package tws_pkg;
	// Register byte offsets
	localparam logic [3:0] TWS_ADDR_MODE   = 4'h0;
	localparam logic [3:0] TWS_ADDR_BUSCTL = 4'h4;
	localparam logic [3:0] TWS_ADDR_SHIFT  = 4'h8;
	localparam logic [3:0] TWS_ADDR_STATUS = 4'hC;
	// serial_mode_control fields
	localparam int TWS_MODE_TXE = 7;
	localparam int TWS_MODE_RXE = 6;
	localparam int TWS_MODE_BUS = 5;
	localparam int TWS_MODE_WUP = 3;
	localparam logic [7:0] TWS_MODE_RST = 8'h00;
	// serial_bus_control fields
	localparam int TWS_BC_BUSY_EN = 7;
	localparam int TWS_BC_ACK_DET = 6;
	localparam int TWS_BC_ACK_EN  = 5;
	localparam int TWS_BC_CMD_DET = 3;
	localparam int TWS_BC_REL_DET = 2;
	localparam logic [7:0] TWS_BC_RST = 8'h00;
	// Status fields
	localparam int TWS_ST_BUSY = 0;
	localparam int TWS_ST_CNT  = 4;
	// Bus responses
	localparam logic [1:0] TWS_RESP_OK  = 2'h0;
	localparam logic [1:0] TWS_RESP_ERR = 2'h2;
	// Internal serial clock half period, rounded up to whole cycles
	localparam int TWS_CLK_PERIOD_NS = 5;
	localparam int TWS_SCK_HALF_NS   = 40;
	localparam int TWS_SCK_HALF_INT  =
		(TWS_SCK_HALF_NS + TWS_CLK_PERIOD_NS - 1) / TWS_CLK_PERIOD_NS;
	localparam logic [7:0] TWS_SCK_HALF = 8'(TWS_SCK_HALF_INT - 1);
	localparam logic [2:0] TWS_LAST_BIT = 3'h7;
	// Transfer states, Gray along idle-run-stop
	typedef enum logic [1:0] {
		TWS_IDLE = 2'h0,
		TWS_RUN  = 2'h1,
		TWS_STOP = 2'h3
	} tws_state_t;
	// Serial pin outputs with enables
	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic so_o;
		logic so_oe;
	} tws_pins_t;
endpackage

// >>> rtl/tws_top.sv
// Three-wire synchronous serial port with AXI4-Lite register slave
// Overview of operation
// R1 - Raise transfer_done_irq at the eighth rising serial clock edge.
// R2 - Busy/ack output and release/command/ack detection stay idle in three-wire mode.
// R3 - Mode register is 8-bit, read/write, resets to zero.
// R4 - Software writes zero into mode bits 2 and 4.
// R5 - Software never flips transmit and receive enables oppositely in one write.
// R6 - Bus control b7..b0: busy_en ack_det ack_en ack_trig cmd_det rel_det cmd_trig rel_trig.
// R7 - Write-only bus control bits read back as zero.
// R8 - Bus control is 8-bit, used only in bus mode, resets zero.
// R9 - Detected flags clear whenever both enables are zero.
// R10 - Data moves eight bits, one per clock, MSB first.
// R11 - Output changes on falling edges, input sampled on rising edges.
// R12 - Internal clock stops after eighth rising edge and idles high.
// R13 - Shift register write with transmit enabled starts a transfer.
// R14 - Serial output floats whenever transmit enable is zero.
// R15 - Transmit-only transfers still shift serial input in.
// R16 - Internal clock first goes low within one clock period of start.
// R17 - Transmit cleared, internal clock: stop at next rise, no irq.
// R18 - External clock before start causes no shift, output unchanged.
// R19 - Transmit cleared, external clock: halt, ignore clock, no irq.
// R20 - Receive-only starts on receive enable rise or shift register read.
// R21 - Receive cleared, internal clock: stop at next rise, no irq.
// R22 - Receive cleared, external clock: halt, ignore clock, no irq.
// R23 - Clearing both enables resets the bit counter.
// R24 - Both enabled: start on shift write or receive enable rise.
// R25 - External serial clock is synchronised before use.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module tws_top
	import tws_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sck_in,
	input  wire logic        si_in,
	output tws_pins_t        pins,
	output logic             transfer_done_irq
);
	localparam int FIRST_LOW_MAX = 17;

	tws_state_t  state_r;
	logic [7:0]  mode_r;
	logic [7:0]  busctl_r;
	logic [2:0]  det_r;
	logic [7:0]  shift_r;
	logic [2:0]  bit_cnt_r;
	logic [7:0]  div_r;
	logic        sck_int_r;
	logic        so_r;
	logic        rxe_q_r;
	logic        irq_r;
	logic        sck_s1_r, sck_s2_r, sck_s3_r;
	logic        si_s1_r, si_s2_r;
	logic        aw_hold_r, w_hold_r;
	logic [3:0]  awaddr_r;
	logic [7:0]  wdata_r;
	logic        wlane_r;
	logic        bvalid_r, rvalid_r;
	logic [1:0]  bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic        rd_bus_r;

	logic txe, rxe, bus_mode, ext_clk, any_en;
	logic do_wr, ar_hs, wr_shift, rd_shift, start, abort;
	logic tick, ser_rise, ser_fall, ext_rise, ext_fall;

	assign txe      = mode_r[TWS_MODE_TXE];
	assign rxe      = mode_r[TWS_MODE_RXE];
	assign bus_mode = mode_r[TWS_MODE_BUS];
	assign ext_clk  = (mode_r[1:0] == 2'h0);
	assign any_en   = txe | rxe;

	// Two-stage synchronisers; edges taken from stage two onward
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_s1_r <= 1'b1;
			sck_s2_r <= 1'b1;
			sck_s3_r <= 1'b1;
			si_s1_r  <= 1'b0;
			si_s2_r  <= 1'b0;
		end else if (clk_en) begin
			sck_s1_r <= sck_in; // R25
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
			si_s1_r  <= si_in;
			si_s2_r  <= si_s1_r;
		end
	end
	assign ext_rise = sck_s2_r & ~sck_s3_r; // R25
	assign ext_fall = ~sck_s2_r & sck_s3_r;

	// Bus write channel: address and data taken in either order
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready  = !w_hold_r && !bvalid_r;
	assign do_wr         = aw_hold_r && w_hold_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= 4'h0;
			wdata_r   <= 8'h00;
			wlane_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= TWS_RESP_OK;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= {s_axi_awaddr[3:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata[7:0];
				wlane_r  <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= (awaddr_r == TWS_ADDR_STATUS) ? TWS_RESP_ERR : TWS_RESP_OK;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end
	assign wr_shift = do_wr && wlane_r && (awaddr_r == TWS_ADDR_SHIFT);

	// Bus read channel; shift register read can kick off reception
	assign s_axi_arready = !rvalid_r;
	assign ar_hs         = s_axi_arvalid && !rvalid_r;
	assign rd_shift      = ar_hs && (s_axi_araddr[3:2] == TWS_ADDR_SHIFT[3:2]);
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= TWS_RESP_OK;
			rd_bus_r <= 1'b0;
		end else if (clk_en) begin
			if (ar_hs) begin
				rvalid_r <= 1'b1;
				rresp_r  <= TWS_RESP_OK;
				rd_bus_r <= 1'b0;
				case ({s_axi_araddr[3:2], 2'h0})
					TWS_ADDR_MODE:   rdata_r <= {24'h000000, mode_r};
					TWS_ADDR_BUSCTL: begin
						// Trigger bits are write-only and read as zero
						rdata_r  <= {24'h000000, busctl_r[TWS_BC_BUSY_EN], det_r[2],
							busctl_r[TWS_BC_ACK_EN], 1'b0, det_r[1], det_r[0],
							2'h0}; // R7 R6
						rd_bus_r <= 1'b1;
					end
					TWS_ADDR_SHIFT:  rdata_r <= {24'h000000, shift_r};
					TWS_ADDR_STATUS: rdata_r <= {25'h0000000, bit_cnt_r, 3'h0,
						state_r != TWS_IDLE};
					default: begin
						rdata_r <= 32'h0000_0000;
						rresp_r <= TWS_RESP_ERR;
					end
				endcase
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Mode register, all bits stored as written
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= TWS_MODE_RST; // R3
		end else if (clk_en && do_wr && wlane_r && awaddr_r == TWS_ADDR_MODE) begin
			mode_r <= wdata_r; // R3
		end
	end

	// Bus control: only the read/write bits hold state here
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busctl_r <= TWS_BC_RST; // R8
		end else if (clk_en && do_wr && wlane_r && awaddr_r == TWS_ADDR_BUSCTL) begin
			busctl_r <= wdata_r & 8'hA0; // R6
		end
	end

	// Detection flags; detectors never run in three-wire mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			det_r <= 3'h0; // R8
		end else if (clk_en) begin
			if (!any_en) begin
				det_r <= 3'h0; // R9
			end else if (!bus_mode) begin
				det_r <= 3'h0; // R2
			end
		end
	end

	// Receive enable history for the 0-to-1 start condition
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxe_q_r <= 1'b0;
		end else if (clk_en) begin
			rxe_q_r <= rxe;
		end
	end

	// Start and abort decode; bus mode is not built, so it never starts
	always_comb begin
		start = 1'b0;
		if (state_r == TWS_IDLE && !bus_mode) begin
			if (txe && wr_shift) begin
				start = 1'b1; // R13 R24
			end else if (rxe && !rxe_q_r) begin
				start = 1'b1; // R20 R24
			end else if (rxe && !txe && rd_shift) begin
				start = 1'b1; // R20
			end
		end
	end
	assign abort = (state_r == TWS_RUN) && !any_en;

	// Internal clock divider: runs only while a transfer is live
	assign tick = (div_r == TWS_SCK_HALF);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r     <= 8'h00;
			sck_int_r <= 1'b1;
		end else if (clk_en) begin
			if (state_r == TWS_IDLE || ext_clk) begin
				div_r     <= 8'h00;
				sck_int_r <= 1'b1; // R12
			end else if (tick) begin
				div_r     <= 8'h00;
				sck_int_r <= ~sck_int_r; // R16
			end else begin
				div_r <= div_r + 8'h01;
			end
		end
	end

	// Serial edges, ignored outside a transfer
	always_comb begin
		ser_rise = 1'b0;
		ser_fall = 1'b0;
		if (state_r != TWS_IDLE) begin
			if (ext_clk) begin
				ser_rise = ext_rise;
				ser_fall = ext_fall;
			end else begin
				ser_rise = tick && !sck_int_r;
				ser_fall = tick && sck_int_r;
			end
		end
	end

	// Transfer sequencer and bit counter
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r   <= TWS_IDLE;
			bit_cnt_r <= 3'h0;
			irq_r     <= 1'b0;
		end else if (clk_en) begin
			irq_r <= 1'b0;
			if (!any_en) begin
				bit_cnt_r <= 3'h0; // R23
			end
			case (state_r)
				TWS_IDLE: begin
					if (start) begin
						state_r   <= TWS_RUN;
						bit_cnt_r <= 3'h0;
					end
				end
				TWS_RUN: begin
					if (abort) begin
						// External clock halts at once, internal waits for a rise
						state_r <= ext_clk ? TWS_IDLE : TWS_STOP; // R19 R22
					end else if (ser_rise) begin
						bit_cnt_r <= bit_cnt_r + 3'h1; // R10
						if (bit_cnt_r == TWS_LAST_BIT) begin
							state_r <= TWS_IDLE; // R12
							irq_r   <= 1'b1; // R1
						end
					end
				end
				TWS_STOP: begin
					if (ser_rise) begin
						state_r <= TWS_IDLE; // R17 R21
					end
				end
				default: state_r <= TWS_IDLE;
			endcase
		end
	end
	assign transfer_done_irq = irq_r;

	// Shift register: loaded by software, sampled on rising edges
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_r <= 8'h00;
		end else if (clk_en) begin
			if (state_r == TWS_IDLE && wr_shift) begin
				shift_r <= wdata_r;
			end else if (state_r == TWS_RUN && ser_rise) begin
				shift_r <= {shift_r[6:0], si_s2_r}; // R10 R11 R15
			end
		end
	end

	// Output latch changes only on falling edges of a live transfer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			so_r <= 1'b1;
		end else if (clk_en && state_r == TWS_RUN && ser_fall && txe) begin
			so_r <= shift_r[7]; // R11 R18
		end
	end

	// Pins: clock driven only with internal source
	assign pins.sck_o  = sck_int_r;
	assign pins.sck_oe = !ext_clk && !bus_mode;
	assign pins.so_o   = so_r;
	assign pins.so_oe  = txe && !bus_mode; // R14

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_irq_eighth_rise: assert property ( // R1
		transfer_done_irq |-> $past(ser_rise) && $past(bit_cnt_r) == 3'h7)
		else $error("irq not at eighth rising edge");
	chk_ro_zero_read: assert property ( // R7
		(clk_en && s_axi_rvalid && rd_bus_r) |->
		s_axi_rdata[4] == 1'b0 && s_axi_rdata[1:0] == 2'h0)
		else $error("write-only bus control bit read nonzero");
	chk_flags_cleared: assert property ( // R9
		(clk_en && !any_en) |=> det_r == 3'h0)
		else $error("detect flags not cleared");
	chk_sck_idle_high: assert property ( // R12
		(state_r == TWS_IDLE) |-> pins.sck_o)
		else $error("internal clock not high while idle");
	chk_tx_start: assert property ( // R13
		(clk_en && start && txe && wr_shift) |=> state_r == TWS_RUN)
		else $error("shift write did not start transfer");
	chk_so_float: assert property ( // R14
		!txe |-> !pins.so_oe)
		else $error("serial output driven with transmit off");
	chk_first_low: assert property ( // R16
		(clk_en && start && !ext_clk) |-> ##[1:FIRST_LOW_MAX]
		(!sck_int_r || !clk_en || state_r == TWS_IDLE))
		else $error("first clock low came late");
	chk_stop_no_irq: assert property ( // R17
		(state_r == TWS_STOP) |=> !transfer_done_irq)
		else $error("interrupt raised after abort");
	chk_idle_so_hold: assert property ( // R18
		(state_r == TWS_IDLE) |=> $stable(so_r))
		else $error("serial output moved outside a transfer");
	chk_msb_out: assert property ( // R10
		(clk_en && state_r == TWS_RUN && ser_fall && txe) |=>
		so_r == $past(shift_r[7]))
		else $error("output bit is not shift MSB");
	chk_ext_abort: assert property ( // R19
		(clk_en && abort && ext_clk) |=> state_r == TWS_IDLE ##1 !transfer_done_irq)
		else $error("external abort did not halt");

	cov_full_byte: cover property (transfer_done_irq);
	cov_int_abort: cover property (state_r == TWS_STOP ##[1:40] state_r == TWS_IDLE);
	cov_rx_start: cover property (clk_en && start && rxe && !txe);
	cov_ext_run: cover property (state_r == TWS_RUN && ext_clk && ext_rise);
endmodule

// >>> test/tws_peer.sv
// Serial peripheral model for the far side of the three-wire link
`timescale 1ns/1ps
module tws_peer
	import tws_pkg::*;
(
	input  tws_pins_t  pins,
	output logic       sck_in,
	output logic       si_in,
	output logic [7:0] got
);
	logic       ext_sck = 1'h1;
	logic [7:0] tx_r    = 8'h00;
	int         cnt     = 0;
	wire        sck_w   = pins.sck_oe ? pins.sck_o : ext_sck;

	// Shared clock line, our clock only when the port is not driving
	assign sck_in = sck_w;
	initial si_in = 1'h0;
	initial got = 8'h00;

	// Next bit on falling edges, MSB first
	always @(negedge sck_w) begin
		si_in = tx_r[7];
		tx_r = {tx_r[6:0], 1'h0};
	end

	// Capture on rising edges; data line toggles after a frame so stale bits never match
	always @(posedge sck_w) begin
		got = {got[6:0], (pins.so_oe ? pins.so_o : 1'hz)};
		cnt++;
		if (cnt % 8 == 0) #20 si_in = ~si_in;
	end

	task automatic load(input logic [7:0] b);
		tx_r = b;
		cnt = 0;
	endtask

	// Clock runs only inside a frame, 48 ns period, idles high
	task automatic burst(input logic [7:0] b, input int n);
		load(b);
		repeat (n) begin
			#24 ext_sck = 1'h0;
			#24 ext_sck = 1'h1;
		end
	endtask
endmodule

// >>> test/three_wire_sync_serial_bench.sv
// Register-level bench for the three-wire serial port
`timescale 1ns/1ps
module three_wire_sync_serial_bench
	import tws_pkg::*;
;
	logic        sys_clk = 1'h0, rst_n = 1'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        sck_in, si_in, transfer_done_irq, s0;
	logic        clk_en = 1'h1;
	tws_pins_t   pins;
	logic [7:0]  got, d;
	int          n_fail = 0, tests_run = 0, irq_n = 0, k;

	always #2.5 sys_clk = ~sys_clk;

	tws_top tws_top_inst (.sys_clk, .rst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.sck_in, .si_in, .pins, .transfer_done_irq);

	tws_peer tws_peer_inst (.pins, .sck_in, .si_in, .got);

	// Pulse counter, so a missing or doubled interrupt shows
	always @(posedge sys_clk) if (transfer_done_irq === 1'h1) irq_n <= irq_n + 1;

	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", n, exp, seen);
		end
	endtask

	// Write: both channels offered together, each dropped once taken
	task automatic axw(input logic [3:0] a, input logic [7:0] v);
		logic aw, w;
		aw = 1'h1;
		w = 1'h1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (aw || w) begin
			@(posedge sys_clk);
			if (aw && s_axi_awready === 1'h1) begin
				aw = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w && s_axi_wready === 1'h1) begin
				w = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end
		while (s_axi_bvalid !== 1'h1) @(posedge sys_clk);
		chk("bresp", {6'h00, s_axi_bresp}, {6'h00, TWS_RESP_OK});
		s_axi_bready <= 1'h0;
		// Spacer edge, avoids a second assignment in one step
		@(posedge sys_clk);
	endtask

	task automatic axr(input logic [3:0] a, output logic [7:0] v);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'h1);
		v = s_axi_rdata[7:0];
		chk("rresp", {6'h00, s_axi_rresp}, {6'h00, TWS_RESP_OK});
		s_axi_rready <= 1'h0;
		@(posedge sys_clk);
	endtask

	// Bounded wait, then the count of pulses seen must match
	task automatic wait_irq(input int n);
		int start;
		start = irq_n;
		for (k = 0; k < 400 && irq_n == start; k++) @(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
		chk("irq count", 8'(irq_n - start), 8'(n));
	endtask

	// One internally clocked transmit with input captured alongside
	task automatic run_int(input logic [7:0] tx, input logic [7:0] rx);
		tws_peer_inst.load(rx);
		axw(TWS_ADDR_SHIFT, tx);
		for (k = 0; k < 17 && pins.sck_o !== 1'h0; k++) @(posedge sys_clk);
		chk("first low", 8'(k < 17), 8'h01);
		wait_irq(1);
		chk("peer data", got, tx);
		chk("sck idle", 8'(pins.sck_o), 8'h01);
		axr(TWS_ADDR_SHIFT, d);
		chk("shift in", d, rx);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Watchdog, generous against some 2100 expected cycles
	initial begin
		#50000;
		n_fail++;
		end_of_test;
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		axr(TWS_ADDR_MODE, d);
		chk("mode reset", d, TWS_MODE_RST);
		axr(TWS_ADDR_BUSCTL, d);
		chk("busctl reset", d, TWS_BC_RST);
		axw(TWS_ADDR_BUSCTL, 8'hFF);
		axr(TWS_ADDR_BUSCTL, d);
		chk("busctl bits", d, 8'hA0);
		axw(TWS_ADDR_MODE, 8'h0B);
		axr(TWS_ADDR_MODE, d);
		chk("mode rw", d, 8'h0B);
		chk("so float", 8'(pins.so_oe), 8'h00);
		chk("sck drive", 8'(pins.sck_oe), 8'h01);
		$display("register test done");
		axw(TWS_ADDR_MODE, 8'h81);
		run_int(8'hA5, 8'h3C);
		// Abort mid-frame by dropping both enables
		axw(TWS_ADDR_SHIFT, 8'h0F);
		// Frozen port: a running clock would be low by now
		clk_en <= 1'h0;
		repeat (28) @(posedge sys_clk);
		chk("frozen sck", 8'(pins.sck_o), 8'h01);
		clk_en <= 1'h1;
		repeat (40) @(posedge sys_clk);
		axw(TWS_ADDR_MODE, 8'h01);
		wait_irq(0);
		chk("abort float", 8'(pins.so_oe), 8'h00);
		chk("abort sck", 8'(pins.sck_o), 8'h01);
		axw(TWS_ADDR_MODE, 8'h81);
		run_int(8'hC3, 8'h96);
		// Both enabled, started by the receive enable rising
		tws_peer_inst.load(8'h69);
		axw(TWS_ADDR_MODE, 8'hC1);
		wait_irq(1);
		chk("both out", got, 8'h96);
		axr(TWS_ADDR_SHIFT, d);
		chk("both in", d, 8'h69);
		$display("internal clock test done");
		axw(TWS_ADDR_MODE, 8'h00);
		s0 = pins.so_o;
		tws_peer_inst.burst(8'h11, 8);
		wait_irq(0);
		axr(TWS_ADDR_SHIFT, d);
		chk("no shift idle", d, 8'h69);
		chk("so held", 8'(pins.so_o), 8'(s0));
		axw(TWS_ADDR_MODE, 8'h40);
		tws_peer_inst.burst(8'h5A, 8);
		wait_irq(1);
		// Reading the shift register rearms a receive-only port
		axr(TWS_ADDR_SHIFT, d);
		chk("ext rx", d, 8'h5A);
		tws_peer_inst.burst(8'hE7, 8);
		wait_irq(1);
		axw(TWS_ADDR_MODE, 8'h00);
		axr(TWS_ADDR_SHIFT, d);
		chk("rx by read", d, 8'hE7);
		// Receive abort with external clock, later pulses ignored
		axw(TWS_ADDR_MODE, 8'h40);
		tws_peer_inst.burst(8'h33, 3);
		// Burst ends between edges; realign before touching the bus
		@(posedge sys_clk);
		axw(TWS_ADDR_MODE, 8'h00);
		tws_peer_inst.burst(8'h33, 8);
		wait_irq(0);
		axr(TWS_ADDR_STATUS, d);
		chk("halt status", d, 8'h00);
		$display("external clock test done");
		end_of_test;
	end
endmodule
